// File: shared/fsr_pkg.sv
// constants for the flash self-rewrite control block
// assumes a 32-bit classic wishbone slave with byte offsets, low byte used
package fsr_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL_A = 8'h00; // flash_ctrl_reg_a
  localparam logic [7:0] OFF_CTRL_B = 8'h04; // flash_ctrl_reg_b
  localparam logic [7:0] OFF_CFG = 8'h08; // wait and pin function config
  localparam logic [7:0] OFF_CMD = 8'h0C; // program / erase command
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10; // sticky events, write 1 clears
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14; // interrupt enables

  // flash_ctrl_reg_a fields
  localparam int CA_RDY_BIT = 0; // ready_busy_flag, read only
  localparam int CA_CPU_EN_BIT = 1; // cpu_rewrite_enable
  localparam int CA_PROT_BIT = 2; // rewrite_protect_release
  // flash_ctrl_reg_b fields
  localparam int CB_FMODE_BIT = 1; // flash_resident_mode_select
  localparam int CB_SBW_BIT = 7; // small_block_wait
  // config fields
  localparam int CFG_GWS_BIT = 0; // global_wait_state
  localparam int CFG_NMIF_BIT = 1; // nmi_pin_function_select
  // command fields
  localparam int CMD_PROG_BIT = 0;
  localparam int CMD_ERASE_BIT = 1;
  // interrupt status / mask fields
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;
  localparam int IRQ_N = 2;

  // bits guarded by the write-0-then-1 sequence
  localparam int LOCK_N = 3;
  localparam int LK_CPU_EN = 0;
  localparam int LK_PROT = 1;
  localparam int LK_FMODE = 2;

  // reset values
  localparam logic [LOCK_N-1:0] LOCK_RST = 3'h0;
  localparam logic SBW_RST = 1'b0;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [IRQ_N-1:0] IRQ_RST = 2'h0;

  // extra access cycles for one wait state
  localparam int WAIT_CYC = 1;

  // flash operation state, gray along idle -> prog and idle -> erase
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10
  } fsr_op_t;

endpackage

// File: design/fsr_wait.sv
// access wait-state generator for flash and internal ram accesses
// assumes one request pulse at a time, next request only after the ack
`timescale 1ns/1ps
module fsr_wait
  import fsr_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic acc_req, // access request pulse
  input wire logic acc_small_blk, // access targets one of the small blocks
  input wire logic small_block_wait, // force one wait on small blocks
  input wire logic global_wait_state, // wait on every access
  output logic acc_ack // access complete pulse
);

  logic pend_reg; // one wait state still to run
  logic ack_reg;
  wire need_wait;

  // small blocks obey their own bit when set, all else the global bit
  assign need_wait = (acc_small_blk & small_block_wait) | global_wait_state;

  // a single flop is enough while WAIT_CYC stays at one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      pend_reg <= acc_req & need_wait;
      ack_reg <= (acc_req & ~need_wait) | pend_reg;
    end
  end

  assign acc_ack = ack_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_small_req;
    acc_req && acc_small_blk && small_block_wait;
  endsequence

  a_small_one_wait: assert property (s_small_req |=> !acc_ack ##1 acc_ack)
    else $error("small block access did not get exactly one wait state");
  a_other_global: assert property ((acc_req && !acc_small_blk) |=> acc_ack == !global_wait_state)
    else $error("non-small access wait not set by global bit alone");
  a_small_no_force: assert property ((acc_req && acc_small_blk && !small_block_wait
      && !global_wait_state) |=> acc_ack)
    else $error("small block access waited with both wait bits clear");

endmodule

// File: design/fsr_ctrl.sv
// flash self-rewrite control: register file, unlock sequence, busy flag,
// command abort, interrupt status and access wait-state selection
// assumes nmi/watchdog/reset-2 pulses come from logic on clk_sys, the nmi
// pin arrives asynchronously, and the flash array reports done as a pulse
//
// How it works
// - ram-resident mode, nmi or watchdog returns both control registers to reset.
// - flash-resident mode, nmi returns both control registers to reset.
// - nmi or watchdog stops a running rewrite; software restarts it afterwards.
// - guarded bits set only by a 0 write then a 1 write back to back.
// - unlock works if pin is a port, or nmi function with pin high.
// - ready/busy reads 0 through program or erase, back to 1 after.
// - reset 1, reset 2, nmi or watchdog aborts a running program or erase.
// - small-block wait bit set gives one wait state on small blocks.
// - other blocks and ram follow only the global wait bit.
`timescale 1ns/1ps
module fsr_ctrl
  import fsr_pkg::*;
(
  input wire logic clk_sys, // system clock, 200 MHz
  input wire logic rst_b, // hardware reset 1, async, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic hw_reset2_i, // hardware reset 2 pulse
  input wire logic nmi_take_i, // nmi accepted pulse
  input wire logic wdt_take_i, // watchdog interrupt accepted pulse
  input wire logic shared_port_pin_i, // shared nmi / port pin level, async
  input wire logic flash_done_i, // flash array operation finished pulse
  output logic flash_prog_o, // start auto program pulse
  output logic flash_erase_o, // start auto erase pulse
  output logic flash_abort_o, // abort running operation pulse
  input wire logic acc_req_i, // cpu access request pulse
  input wire logic acc_small_blk_i, // access hits a small block
  output logic acc_ack_o, // cpu access complete pulse
  output logic irq_o // level interrupt
);

  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic nmi_pin_meta_reg;
  logic nmi_pin_sync_reg;
  logic [LOCK_N-1:0] lock_reg;
  logic [LOCK_N-1:0] lock_next;
  logic [LOCK_N-1:0] armed_reg;
  logic [LOCK_N-1:0] armed_next;
  logic sbw_reg;
  logic sbw_next;
  logic [1:0] cfg_reg;
  logic [1:0] cfg_next;
  logic [IRQ_N-1:0] mask_reg;
  logic [IRQ_N-1:0] mask_next;
  logic [IRQ_N-1:0] stat_reg;
  logic [IRQ_N-1:0] stat_next;
  logic irq_reg;
  fsr_op_t op_reg;
  fsr_op_t op_next;
  logic prog_reg;
  logic erase_reg;
  logic abort_reg;

  // bus decode; a write lands on the edge that sees ack high
  wire bus_req;
  wire wr_fire;
  wire [7:0] wr_byte;
  wire wr_a;
  wire wr_b;
  wire wr_cfg;
  wire wr_cmd;
  wire wr_stat;
  wire wr_mask;
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign ack_next = bus_req & ~ack_reg;
  assign wr_fire = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];
  assign wr_a = wr_fire & (wb_adr_i == OFF_CTRL_A);
  assign wr_b = wr_fire & (wb_adr_i == OFF_CTRL_B);
  assign wr_cfg = wr_fire & (wb_adr_i == OFF_CFG);
  assign wr_cmd = wr_fire & (wb_adr_i == OFF_CMD);
  assign wr_stat = wr_fire & (wb_adr_i == OFF_IRQ_STAT);
  assign wr_mask = wr_fire & (wb_adr_i == OFF_IRQ_MASK);

  // modes derived from the guarded bits
  wire ram_mode;
  wire flash_mode;
  assign ram_mode = lock_reg[LK_CPU_EN] & ~lock_reg[LK_FMODE];
  assign flash_mode = lock_reg[LK_CPU_EN] & lock_reg[LK_FMODE];

  // events that abort and events that reinitialise the control registers
  wire abort_ev;
  wire reg_clr;
  assign abort_ev = hw_reset2_i | nmi_take_i | wdt_take_i;
  assign reg_clr = hw_reset2_i | (nmi_take_i & (ram_mode | flash_mode))
    | (wdt_take_i & ram_mode);

  // nmi pin synchroniser; only the second stage is read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      nmi_pin_meta_reg <= 1'b0;
      nmi_pin_sync_reg <= 1'b0;
    end else begin
      nmi_pin_meta_reg <= shared_port_pin_i;
      nmi_pin_sync_reg <= nmi_pin_meta_reg;
    end
  end

  // unlock allowed with port function, or nmi function and pin high
  wire unlock_ok;
  assign unlock_ok = ~cfg_reg[CFG_NMIF_BIT] | nmi_pin_sync_reg;

  // per guarded bit: a 0 write arms, the very next bus write of 1 sets
  wire [LOCK_N-1:0] lk_hit;
  wire [LOCK_N-1:0] lk_val;
  assign lk_hit = {wr_b, wr_a, wr_a};
  assign lk_val = {wr_byte[CB_FMODE_BIT], wr_byte[CA_PROT_BIT], wr_byte[CA_CPU_EN_BIT]};
  generate
    for (genvar i = 0; i < LOCK_N; i++) begin : g_lock
      // a lone 1 leaves a cleared bit cleared
      assign lock_next[i] = reg_clr ? 1'b0 :
        lk_hit[i] ? (lk_val[i] & (lock_reg[i] | (armed_reg[i] & unlock_ok))) :
        lock_reg[i];
      // any other write in between breaks the sequence
      assign armed_next[i] = reg_clr ? 1'b0 :
        lk_hit[i] ? ~lk_val[i] :
        (wr_fire ? 1'b0 : armed_reg[i]);
    end
  endgenerate

  // plain register next values
  assign sbw_next = reg_clr ? SBW_RST : (wr_b ? wr_byte[CB_SBW_BIT] : sbw_reg);
  assign cfg_next = wr_cfg ? {wr_byte[CFG_NMIF_BIT], wr_byte[CFG_GWS_BIT]} : cfg_reg;
  assign mask_next = wr_mask ? {wr_byte[IRQ_ABORT_BIT], wr_byte[IRQ_DONE_BIT]} : mask_reg;

  // command start needs rewrite enabled, idle, and no abort this cycle
  wire op_busy;
  wire cmd_prog;
  wire cmd_erase;
  wire start_ok;
  wire ev_done;
  wire ev_abort;
  assign op_busy = op_reg != OP_IDLE;
  assign cmd_prog = wr_cmd & wr_byte[CMD_PROG_BIT];
  assign cmd_erase = wr_cmd & wr_byte[CMD_ERASE_BIT];
  assign start_ok = (cmd_prog | cmd_erase) & lock_reg[LK_CPU_EN] & ~op_busy & ~abort_ev;
  assign ev_done = op_busy & flash_done_i & ~abort_ev;
  assign ev_abort = op_busy & abort_ev;

  // operation state; abort outranks a done in the same cycle
  always_comb begin
    op_next = op_reg;
    case (op_reg)
      OP_IDLE: begin
        if (start_ok) begin
          op_next = cmd_prog ? OP_PROG : OP_ERASE;
        end
      end
      OP_PROG, OP_ERASE: begin
        if (abort_ev || flash_done_i) begin
          op_next = OP_IDLE;
        end
      end
      default: begin
        op_next = OP_IDLE;
      end
    endcase
  end

  // sticky status: a new event wins over a clear in the same cycle
  wire [IRQ_N-1:0] ev_vec;
  wire [IRQ_N-1:0] clr_vec;
  assign ev_vec = {ev_abort, ev_done};
  assign clr_vec = wr_stat ? {wr_byte[IRQ_ABORT_BIT], wr_byte[IRQ_DONE_BIT]} : IRQ_RST;
  assign stat_next = (stat_reg & ~clr_vec) | ev_vec;

  // read data; unmapped offsets read zero and still acknowledge
  wire [7:0] ctrl_a_rd;
  wire [7:0] ctrl_b_rd;
  wire [7:0] cfg_rd;
  wire [7:0] stat_rd;
  wire [7:0] mask_rd;
  wire [7:0] rd_byte;
  // logical not keeps the flag one bit wide before the cast pads it
  assign ctrl_a_rd = (8'(!op_busy) << CA_RDY_BIT)
    | (8'(lock_reg[LK_CPU_EN]) << CA_CPU_EN_BIT)
    | (8'(lock_reg[LK_PROT]) << CA_PROT_BIT);
  assign ctrl_b_rd = (8'(lock_reg[LK_FMODE]) << CB_FMODE_BIT) | (8'(sbw_reg) << CB_SBW_BIT);
  assign cfg_rd = (8'(cfg_reg[0]) << CFG_GWS_BIT) | (8'(cfg_reg[1]) << CFG_NMIF_BIT);
  assign stat_rd = (8'(stat_reg[0]) << IRQ_DONE_BIT) | (8'(stat_reg[1]) << IRQ_ABORT_BIT);
  assign mask_rd = (8'(mask_reg[0]) << IRQ_DONE_BIT) | (8'(mask_reg[1]) << IRQ_ABORT_BIT);
  assign rd_byte = (wb_adr_i == OFF_CTRL_A) ? ctrl_a_rd :
    (wb_adr_i == OFF_CTRL_B) ? ctrl_b_rd :
    (wb_adr_i == OFF_CFG) ? cfg_rd :
    (wb_adr_i == OFF_IRQ_STAT) ? stat_rd :
    (wb_adr_i == OFF_IRQ_MASK) ? mask_rd : 8'h00;
  assign dat_next = (bus_req & ~wb_we_i & ~ack_reg) ? {24'h000000, rd_byte} : dat_reg;

  // bus answer and register state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      lock_reg <= LOCK_RST;
      armed_reg <= LOCK_RST;
      sbw_reg <= SBW_RST;
      cfg_reg <= CFG_RST;
      mask_reg <= IRQ_RST;
      stat_reg <= IRQ_RST;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      lock_reg <= lock_next;
      armed_reg <= armed_next;
      sbw_reg <= sbw_next;
      cfg_reg <= cfg_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
    end
  end

  // operation state and flash strobes; reset 1 idles everything at once
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      op_reg <= OP_IDLE;
      prog_reg <= 1'b0;
      erase_reg <= 1'b0;
      abort_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      op_reg <= op_next;
      prog_reg <= start_ok & cmd_prog;
      erase_reg <= start_ok & ~cmd_prog;
      abort_reg <= ev_abort;
      irq_reg <= |(stat_next & mask_next);
    end
  end

  // wait-state selection for cpu accesses
  fsr_wait u_wait (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .acc_req(acc_req_i),
    .acc_small_blk(acc_small_blk_i),
    .small_block_wait(sbw_reg),
    .global_wait_state(cfg_reg[CFG_GWS_BIT]),
    .acc_ack(acc_ack_o)
  );

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign flash_prog_o = prog_reg;
  assign flash_erase_o = erase_reg;
  assign flash_abort_o = abort_reg;
  assign irq_o = irq_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_start;
    start_ok;
  endsequence
  sequence s_unlock_write;
    wr_a && wr_byte[CA_CPU_EN_BIT] && armed_reg[LK_CPU_EN] && unlock_ok && !reg_clr;
  endsequence
  sequence s_blocked_write;
    wr_a && wr_byte[CA_CPU_EN_BIT] && armed_reg[LK_CPU_EN] && !unlock_ok
      && !lock_reg[LK_CPU_EN];
  endsequence

  a_busy_while_op: assert property (s_start |=> (ctrl_a_rd[CA_RDY_BIT] == 1'b0)
      && (flash_prog_o || flash_erase_o))
    else $error("busy flag not low after command start");
  a_done_ready: assert property ((op_busy && flash_done_i && !abort_ev)
      |=> ctrl_a_rd[CA_RDY_BIT] && stat_reg[IRQ_DONE_BIT])
    else $error("ready flag not back after operation finished");
  a_abort_stops: assert property ((op_busy && abort_ev) |=> !op_busy && flash_abort_o
      && stat_reg[IRQ_ABORT_BIT])
    else $error("running operation not aborted");
  a_ram_mode_init: assert property ((ram_mode && (nmi_take_i || wdt_take_i))
      |=> lock_reg == LOCK_RST && sbw_reg == SBW_RST)
    else $error("control registers kept after nmi or watchdog in ram mode");
  a_flash_mode_init: assert property ((flash_mode && nmi_take_i)
      |=> lock_reg == LOCK_RST && sbw_reg == SBW_RST)
    else $error("control registers kept after nmi in flash mode");
  a_lone_one_refused: assert property ((wr_a && wr_byte[CA_CPU_EN_BIT]
      && !armed_reg[LK_CPU_EN] && !lock_reg[LK_CPU_EN]) |=> !lock_reg[LK_CPU_EN])
    else $error("lone write of one set a guarded bit");
  a_unlock_pair: assert property (s_unlock_write |=> lock_reg[LK_CPU_EN])
    else $error("zero then one sequence did not set the bit");
  a_pin_gate: assert property (s_blocked_write |=> !lock_reg[LK_CPU_EN])
    else $error("unlock accepted with nmi function and pin low");
  a_irq_level: assert property (irq_o == |($past(stat_next) & $past(mask_next)))
    else $error("interrupt output disagrees with status and mask");
  a_no_start_locked: assert property ((wr_cmd && !lock_reg[LK_CPU_EN] && !op_busy)
      |=> !flash_prog_o && !flash_erase_o && !op_busy)
    else $error("command started with rewrite disabled");

endmodule

// File: test/fsr_flash_model.sv
// behavioural flash array behind the self-rewrite control block
// assumes start and abort arrive as one-cycle pulses on clk_sys
`timescale 1ns/1ps
module fsr_flash_model #(
  parameter int PROG_CYC = 16,
  parameter int ERASE_CYC = 30
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic start_prog, // auto program start pulse
  input wire logic start_erase, // auto erase start pulse
  input wire logic abort, // stop the running operation
  output logic done // operation finished pulse
);
  int cnt;

  // count down while busy; an abort drops the operation with no done pulse
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      done <= 1'b0;
    end else begin
      done <= (cnt == 1) && !abort;
      if (abort)
        cnt <= 0;
      else if (start_prog)
        cnt <= PROG_CYC;
      else if (start_erase)
        cnt <= ERASE_CYC; // erase kept slower so an abort can land mid-way
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
endmodule

// File: test/flash_self_rewrite_control_tb.sv
// self-checking bench for the flash self-rewrite control block
// assumes the flash model above and the wishbone timing of the block
`timescale 1ns/1ps
module flash_self_rewrite_control_tb;
  import fsr_pkg::*;
  logic clk_sys = 0, rst_b = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, hw2 = 0, nmi = 0, wdt = 0, pin = 1, done, prog, ers, abt;
  logic areq = 0, asmall = 0, aack, irq;
  int n_fail = 0, tests_run = 0, n_start = 0, n_abt = 0, n_prog = 0, seed;
  logic [31:0] expq[$];

  always #2.5 clk_sys = ~clk_sys;

  fsr_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .hw_reset2_i(hw2), .nmi_take_i(nmi), .wdt_take_i(wdt),
    .shared_port_pin_i(pin), .flash_done_i(done), .flash_prog_o(prog),
    .flash_erase_o(ers), .flash_abort_o(abt), .acc_req_i(areq),
    .acc_small_blk_i(asmall), .acc_ack_o(aack), .irq_o(irq));

  fsr_flash_model #(.PROG_CYC(16), .ERASE_CYC(30)) flash (.clk_sys(clk_sys),
    .rst_b(rst_b), .start_prog(prog), .start_erase(ers), .abort(abt), .done(done));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task conclude;
    if (expq.size() != 0)
      n_fail++;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one classic cycle; held until ack is sampled, then released for a cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (ack !== 1'b1)
      n_fail++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  // the expected value is queued; the monitor below makes the compare
  task rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  task ul(input logic [7:0] a, input logic [31:0] m);
    wr(a, 32'h0);
    wr(a, m);
  endtask

  // k: 0 nmi, 1 watchdog, 2 hardware reset 2
  task ev(input int k);
    @(posedge clk_sys);
    nmi <= (k == 0);
    wdt <= (k == 1);
    hw2 <= (k == 2);
    @(posedge clk_sys);
    nmi <= 1'b0;
    wdt <= 1'b0;
    hw2 <= 1'b0;
  endtask

  task wdone;
    int t;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (done !== 1'b1 && t < 100);
    if (done !== 1'b1)
      n_fail++;
    repeat (2) @(posedge clk_sys);
  endtask

  task acc(input logic s, input int lat);
    int n;
    @(posedge clk_sys);
    areq <= 1'b1;
    asmall <= s;
    @(posedge clk_sys);
    areq <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (aack !== 1'b1 && n < 9);
    chk("access latency", lat, n);
  endtask

  // read results and start/abort pulses, seen at the ack or pulse edge
  always @(posedge clk_sys) begin
    if (ack === 1'b1 && we === 1'b0)
      chk("read data", expq.pop_front(), rdat);
    if (prog === 1'b1 || ers === 1'b1)
      n_start++;
    if (prog === 1'b1)
      n_prog++;
    if (abt === 1'b1)
      n_abt++;
  end

  initial begin
    #200000;
    n_fail++;
    conclude;
  end

  initial begin
    logic [7:0] a;
    logic [31:0] m, r;
    logic s, sb, g;
    seed = $urandom(68);
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(OFF_CTRL_A, 32'h01);
    rd(OFF_CTRL_B, 32'h00);
    rd(OFF_CFG, 32'h00);
    rd(OFF_IRQ_MASK, 32'h00);
    wr(8'h40, 32'hFF);
    rd(8'h40, 32'h00);
    // lone one, broken pair, proper pair on each guarded bit
    for (int i = 0; i < 3; i++) begin
      a = (i == 2) ? OFF_CTRL_B : OFF_CTRL_A;
      m = 32'h1 << ((i == 0) ? CA_CPU_EN_BIT : (i == 1) ? CA_PROT_BIT : CB_FMODE_BIT);
      r = (i == 2) ? 32'h00 : 32'h01;
      wr(OFF_IRQ_MASK, 32'h0);
      wr(a, m);
      rd(a, r);
      wr(a, 32'h0);
      wr(OFF_IRQ_MASK, 32'h0);
      wr(a, m);
      rd(a, r);
      ul(a, m);
      rd(a, r | m);
      wr(a, 32'h0);
    end
    // pin in nmi function: unlock only while the pin is high
    wr(OFF_CFG, 32'h1 << CFG_NMIF_BIT);
    pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ul(OFF_CTRL_A, 32'h02);
    rd(OFF_CTRL_A, 32'h01);
    pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ul(OFF_CTRL_A, 32'h02);
    rd(OFF_CTRL_A, 32'h03);
    wr(OFF_CFG, 32'h0);
    // program runs to completion; a command while busy is dropped
    wr(OFF_IRQ_MASK, 32'h3);
    wr(OFF_CMD, 32'h1 << CMD_PROG_BIT);
    rd(OFF_CTRL_A, 32'h02);
    wr(OFF_CMD, 32'h1 << CMD_ERASE_BIT);
    wdone;
    rd(OFF_CTRL_A, 32'h03);
    rd(OFF_IRQ_STAT, 32'h01);
    chk("irq", 1, irq);
    wr(OFF_IRQ_STAT, 32'h1);
    rd(OFF_IRQ_STAT, 32'h00);
    chk("irq", 0, irq);
    // erase cut short by nmi, watchdog and reset 2 in ram-resident mode
    for (int k = 0; k < 3; k++) begin
      ul(OFF_CTRL_A, 32'h02);
      wr(OFF_CMD, 32'h1 << CMD_ERASE_BIT);
      rd(OFF_CTRL_A, 32'h02);
      ev(k);
      rd(OFF_CTRL_A, 32'h01);
      rd(OFF_IRQ_STAT, 32'h02);
      chk("irq", 1, irq);
      wr(OFF_IRQ_STAT, 32'h3);
    end
    // disabled command is ignored
    wr(OFF_CMD, 32'h1 << CMD_PROG_BIT);
    rd(OFF_CTRL_A, 32'h01);
    rd(OFF_IRQ_STAT, 32'h00);
    // reset 1 during an erase stops it without an abort pulse
    ul(OFF_CTRL_A, 32'h02);
    wr(OFF_CMD, 32'h1 << CMD_ERASE_BIT);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(OFF_CTRL_A, 32'h01);
    chk("starts", 5, n_start);
    chk("aborts", 3, n_abt);
    chk("programs", 1, n_prog);
    // flash-resident mode: nmi still reinitialises both registers
    ul(OFF_CTRL_B, 32'h1 << CB_FMODE_BIT);
    ul(OFF_CTRL_A, 32'h02);
    ev(0);
    rd(OFF_CTRL_B, 32'h00);
    rd(OFF_CTRL_A, 32'h01);
    // access waits under random wait settings
    for (int i = 0; i < 16; i++) begin
      s = $urandom % 2;
      sb = $urandom % 2;
      g = $urandom % 2;
      wr(OFF_CTRL_B, {24'h0, sb, 7'h0});
      wr(OFF_CFG, {31'h0, g});
      acc(s, ((s && sb) || g) ? 2 : 1);
    end
    conclude;
  end
endmodule
